// file: tdm_pkg.sv
// Package holding register map, reset values, field positions and carrier types.
package tdm_pkg;

  // Register offsets
  localparam logic [11:0] GAIN_B_ADDR    = 12'h07b;
  localparam logic [11:0] BANDGAP_ADDR   = 12'h07c;
  localparam logic [11:0] TERM_A_ADDR    = 12'h07e;
  localparam logic [11:0] TERM_B_ADDR    = 12'h07f;
  localparam logic [11:0] DITHER_ADDR    = 12'h09d;
  localparam logic [11:0] MARKER_ADDR    = 12'h160;
  localparam logic [11:0] LINK_EN_ADDR   = 12'h200;

  // Reset values for registers without factory content
  localparam logic [7:0]  DITHER_RESET   = 8'h01;
  localparam logic [7:0]  MARKER_RESET   = 8'h00;
  localparam logic [7:0]  LINK_EN_RESET  = 8'h01;
  localparam logic [7:0]  UNMAPPED_READ  = 8'h00;
  localparam logic [3:0]  RESERVED_RESET = 4'h0;

  // Field positions
  localparam int DITHER_EN_BIT    = 0;
  localparam int DITHER_AMP_BIT   = 1;
  localparam int DITHER_ERR_BIT   = 2;
  localparam int MARKER_EN_BIT    = 0;
  localparam int LINK_EN_BIT      = 0;

  // Timing: pin edge to matching sample at the input port, in cycles
  localparam int ANALOG_LATENCY   = 6;
  localparam int SYNC_STAGES      = 2;
  localparam int MARKER_DELAY     = ANALOG_LATENCY - SYNC_STAGES;

  // Control bits per sample advertised in lane alignment data
  localparam logic [1:0]  ILA_CONTROL_BITS = 2'h0;

  // Factory trim bundle as delivered by the fuse logic
  typedef struct packed {
    logic [7:0] gainB;
    logic [3:0] bandgap;
    logic [7:0] termA;
    logic [7:0] termB;
  } tdm_trim_type;

  // Dither control outputs
  typedef struct packed {
    logic enable;
    logic amplitude;
    logic roundErr;
  } tdm_dither_type;

endpackage

// file: tdm_regs.sv
// Trim, dither and sample marker register bank with marker insertion path.
`timescale 1ns/1ps
module tdm_regs
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Factory trim values from fuse logic
  input  wire tdm_pkg::tdm_trim_type factoryTrim,
  // Register port
  input  wire logic [11:0]           regAddr,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  input  wire logic [7:0]            regWdata,
  output logic      [7:0]            regRdata,
  output logic                       regRdataValid,
  // Trim, dither and link enable controls
  output tdm_pkg::tdm_trim_type      trimOut,
  output tdm_pkg::tdm_dither_type    ditherOut,
  output logic                       serialLinkEnable,
  // Sample path
  input  wire logic                  timestampPin,
  input  wire logic                  syncReceiverEnable,
  input  wire logic [7:0]            sampleIn,
  input  wire logic                  sampleInValid,
  output logic      [7:0]            sampleOut,
  output logic                       sampleOutValid,
  output logic      [1:0]            ilaControlBits
);

  logic [7:0] gainB_reg;
  logic [7:0] bandgap_reg;
  logic [7:0] termA_reg;
  logic [7:0] termB_reg;
  logic [7:0] dither_reg;
  logic [7:0] marker_reg;
  logic [7:0] linkEn_reg;
  logic [7:0] readData_next;
  logic       stampSyncA;
  logic       stampSyncB;
  logic [tdm_pkg::MARKER_DELAY-1:0] markerLine;
  logic [2:0] settleCount_reg;

  // Trim registers; factory value taken while reset is held
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      gainB_reg   <= factoryTrim.gainB;
      bandgap_reg <= {tdm_pkg::RESERVED_RESET, factoryTrim.bandgap};
      termA_reg   <= factoryTrim.termA;
      termB_reg   <= factoryTrim.termB;
    end
    else if (regWrite)
    begin
      if (regAddr == tdm_pkg::GAIN_B_ADDR)
        gainB_reg <= regWdata;
      if (regAddr == tdm_pkg::BANDGAP_ADDR)
        bandgap_reg <= regWdata;
      if (regAddr == tdm_pkg::TERM_A_ADDR)
        termA_reg <= regWdata;
      if (regAddr == tdm_pkg::TERM_B_ADDR)
        termB_reg <= regWdata;
    end
  end

  // Control registers; reserved bits kept as plain storage
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dither_reg <= tdm_pkg::DITHER_RESET;
      marker_reg <= tdm_pkg::MARKER_RESET;
      linkEn_reg <= tdm_pkg::LINK_EN_RESET;
    end
    else if (regWrite)
    begin
      if (regAddr == tdm_pkg::DITHER_ADDR)
        dither_reg <= regWdata;
      if (regAddr == tdm_pkg::MARKER_ADDR)
        marker_reg <= regWdata;
      if (regAddr == tdm_pkg::LINK_EN_ADDR)
        linkEn_reg <= regWdata;
    end
  end

  // Read decode; unmapped offsets answer zero
  always_comb
  begin
    case (regAddr)
      tdm_pkg::GAIN_B_ADDR:  readData_next = gainB_reg;
      tdm_pkg::BANDGAP_ADDR: readData_next = bandgap_reg;
      tdm_pkg::TERM_A_ADDR:  readData_next = termA_reg;
      tdm_pkg::TERM_B_ADDR:  readData_next = termB_reg;
      tdm_pkg::DITHER_ADDR:  readData_next = dither_reg;
      tdm_pkg::MARKER_ADDR:  readData_next = marker_reg;
      tdm_pkg::LINK_EN_ADDR: readData_next = linkEn_reg;
      default:               readData_next = tdm_pkg::UNMAPPED_READ;
    endcase
  end

  // Read data held until the next read
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      regRdata      <= tdm_pkg::UNMAPPED_READ;
      regRdataValid <= 1'b0;
    end
    else
    begin
      regRdataValid <= regRead;
      if (regRead)
        regRdata <= readData_next;
    end
  end

  // Control outputs registered so analog side sees clean levels
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      trimOut          <= '0;
      ditherOut        <= '0;
      serialLinkEnable <= 1'b0;
      ilaControlBits   <= tdm_pkg::ILA_CONTROL_BITS;
    end
    else
    begin
      trimOut.gainB      <= gainB_reg;
      trimOut.bandgap    <= bandgap_reg[3:0];                    // Reserved nibble drives nothing
      trimOut.termA      <= termA_reg;
      trimOut.termB      <= termB_reg;
      ditherOut.enable    <= dither_reg[tdm_pkg::DITHER_EN_BIT];
      ditherOut.amplitude <= dither_reg[tdm_pkg::DITHER_AMP_BIT];
      ditherOut.roundErr  <= dither_reg[tdm_pkg::DITHER_ERR_BIT];
      serialLinkEnable <= linkEn_reg[tdm_pkg::LINK_EN_BIT];
      ilaControlBits   <= tdm_pkg::ILA_CONTROL_BITS;            // marker never advertised
    end
  end

  // Timestamp pin synchroniser
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      stampSyncA <= 1'b0;
      stampSyncB <= 1'b0;
    end
    else
    begin
      stampSyncA <= timestampPin;
      stampSyncB <= stampSyncA;
    end
  end

  // Delay line; the sync stages count toward the matched latency
  genvar i;
  generate
    for (i = 0; i < tdm_pkg::MARKER_DELAY; i++)
    begin : g_line
      always_ff @(posedge sys_clk)
      begin
        if (rst)
          markerLine[i] <= 1'b0;
        else if (i == 0)
          markerLine[i] <= stampSyncB & syncReceiverEnable;
        else
          markerLine[i] <= markerLine[(i == 0) ? 0 : i-1];
      end
    end
  endgenerate

  // Output sample; marker overwrites the LSB only when enabled
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sampleOut      <= 8'h00;
      sampleOutValid <= 1'b0;
    end
    else
    begin
      sampleOutValid <= sampleInValid;
      if (marker_reg[tdm_pkg::MARKER_EN_BIT])
        sampleOut <= {sampleIn[7:1], markerLine[tdm_pkg::MARKER_DELAY-1]};
      else
        sampleOut <= sampleIn;
    end
  end

  // Edges since reset, saturating; keeps pipeline checks off reset residue
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      settleCount_reg <= 3'h0;
    else if (settleCount_reg != 3'h7)
      settleCount_reg <= 3'(settleCount_reg + 3'h1);
  end

  // Assertions
  AST_GAIN_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    (regWrite && regAddr == tdm_pkg::GAIN_B_ADDR) ##2 (!$past(rst)) |-> trimOut.gainB == $past(regWdata, 2))
    else $error("gain trim write not applied");
  AST_BANDGAP_LOW: assert property (@(posedge sys_clk) disable iff (rst)
    (regWrite && regAddr == tdm_pkg::BANDGAP_ADDR) |-> ##2 trimOut.bandgap == $past(regWdata[3:0], 2))
    else $error("bandgap trim not taken from low nibble");
  AST_TERM_A: assert property (@(posedge sys_clk) disable iff (rst)
    (regRead && regAddr == tdm_pkg::TERM_A_ADDR) |=> regRdata == $past(termA_reg) && regRdataValid)
    else $error("termination A readback wrong");
  AST_TERM_B_FACTORY: assert property (@(posedge sys_clk)
    $fell(rst) |-> termB_reg == $past(factoryTrim.termB))
    else $error("termination B factory value not loaded");
  AST_DITHER_RESET: assert property (@(posedge sys_clk)
    $fell(rst) |-> dither_reg == 8'h01 ##1 ditherOut.enable)
    else $error("dither not enabled after reset");
  AST_DITHER_BITS: assert property (@(posedge sys_clk) disable iff (rst)
    (regWrite && regAddr == tdm_pkg::DITHER_ADDR) ##2 1'b1 |->
      ditherOut.amplitude == $past(regWdata[1], 2) && ditherOut.roundErr == $past(regWdata[2], 2))
    else $error("dither amplitude or rounding select wrong");
  AST_MARKER_LATENCY: assert property (@(posedge sys_clk) disable iff (rst)
    (settleCount_reg == 3'h7 && $past(marker_reg[0]) && $past(syncReceiverEnable, 5)) |->
      sampleOut[0] == $past(timestampPin, 7))
    else $error("marker latency mismatch");
  AST_UPPER_BITS: assert property (@(posedge sys_clk) disable iff (rst)
    settleCount_reg != 3'h0 && $past(marker_reg[0]) |-> sampleOut[7:1] == $past(sampleIn[7:1]))
    else $error("sample data bits disturbed by marker");
  AST_NO_MARKER: assert property (@(posedge sys_clk) disable iff (rst)
    settleCount_reg != 3'h0 && !$past(marker_reg[0]) |-> sampleOut == $past(sampleIn))
    else $error("sample changed with marker off");
  AST_ILA_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
    marker_reg[0] |-> ##1 ilaControlBits == 2'h0)
    else $error("control bits advertised");
  AST_RESERVED_STORE: assert property (@(posedge sys_clk) disable iff (rst)
    (regWrite && regAddr == tdm_pkg::MARKER_ADDR) |=> marker_reg == $past(regWdata))
    else $error("reserved bits not stored");

  // Factory and reset values on the first edge out of reset
  AST_GAIN_FACTORY: assert property (@(posedge sys_clk)
    $fell(rst) |-> gainB_reg == $past(factoryTrim.gainB))
    else $error("gain trim factory value not loaded");
  AST_BANDGAP_FACTORY: assert property (@(posedge sys_clk)
    $fell(rst) |-> bandgap_reg == {tdm_pkg::RESERVED_RESET, $past(factoryTrim.bandgap)})
    else $error("bandgap trim factory value not loaded");
  AST_TERM_A_FACTORY: assert property (@(posedge sys_clk)
    $fell(rst) |-> termA_reg == $past(factoryTrim.termA))
    else $error("termination A factory value not loaded");
  AST_MARKER_RESET: assert property (@(posedge sys_clk)
    $fell(rst) |-> marker_reg == tdm_pkg::MARKER_RESET)
    else $error("marker control not cleared by reset");

  // Writes reach the analog controls two edges after the strobe; termination B is checked at its register one edge after
  AST_TERM_A_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    (regWrite && regAddr == tdm_pkg::TERM_A_ADDR) |-> ##2 trimOut.termA == $past(regWdata, 2))
    else $error("termination A write not applied");
  AST_TERM_B_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    (regWrite && regAddr == tdm_pkg::TERM_B_ADDR) |=> termB_reg == $past(regWdata))
    else $error("termination B write not stored");
  AST_DITHER_EN_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    (regWrite && regAddr == tdm_pkg::DITHER_ADDR) |-> ##2 ditherOut.enable == $past(regWdata[0], 2))
    else $error("dither enable write not applied");

  // Read answers carry the register as it stood at the request edge
  AST_GAIN_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (regRead && regAddr == tdm_pkg::GAIN_B_ADDR) |=> regRdataValid && regRdata == $past(gainB_reg))
    else $error("gain trim readback wrong");
  AST_BANDGAP_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (regRead && regAddr == tdm_pkg::BANDGAP_ADDR) |=> regRdataValid && regRdata == $past(bandgap_reg))
    else $error("bandgap trim readback wrong");
  AST_TERM_B_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (regRead && regAddr == tdm_pkg::TERM_B_ADDR) |=> regRdataValid && regRdata == $past(termB_reg))
    else $error("termination B readback wrong");
  AST_DITHER_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (regRead && regAddr == tdm_pkg::DITHER_ADDR) |=> regRdataValid && regRdata == $past(dither_reg))
    else $error("dither control readback wrong");
  AST_MARKER_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (regRead && regAddr == tdm_pkg::MARKER_ADDR) |=> regRdataValid && regRdata == $past(marker_reg))
    else $error("marker control readback wrong");
  AST_RDATA_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    !regRead |=> $stable(regRdata))
    else $error("read data changed without a read");
  AST_VALID_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
    !regRead |=> !regRdataValid)
    else $error("read valid without a read");

  // Sample path timing and receiver gating
  AST_VALID_FOLLOW: assert property (@(posedge sys_clk) disable iff (rst)
    settleCount_reg != 3'h0 |-> sampleOutValid == $past(sampleInValid))
    else $error("sample valid not one cycle behind input");
  AST_MARKER_GATED: assert property (@(posedge sys_clk) disable iff (rst)
    (settleCount_reg == 3'h7 && $past(marker_reg[0]) && !$past(syncReceiverEnable, 5)) |-> !sampleOut[0])
    else $error("marker passed with receiver off");

  // Cover points for the main scenarios
  COV_MARKER_ON: cover property (@(posedge sys_clk) disable iff (rst)
    marker_reg[0] && sampleOutValid && sampleOut[0]);
  COV_DITHER_OFF: cover property (@(posedge sys_clk) disable iff (rst)
    regWrite && regAddr == tdm_pkg::DITHER_ADDR && !regWdata[0]);
  COV_TRIM_READ: cover property (@(posedge sys_clk) disable iff (rst)
    regRead && regAddr == tdm_pkg::GAIN_B_ADDR ##1 regRdataValid);
  COV_MARKER_GATED: cover property (@(posedge sys_clk) disable iff (rst)
    marker_reg[0] && !syncReceiverEnable && sampleOutValid);
  COV_RESERVED_WRITE: cover property (@(posedge sys_clk) disable iff (rst)
    regWrite && regAddr == tdm_pkg::BANDGAP_ADDR && regWdata[7:4] != 4'h0);

endmodule

// file: test_tdm_regs.sv
// Self-checking testbench for the trim, dither and sample marker register bank.
`timescale 1ns/1ps
module test_tdm_regs;
  logic                    sys_clk = 1'b0;
  logic                    rst;
  tdm_pkg::tdm_trim_type   factoryTrim;
  tdm_pkg::tdm_trim_type   trimOut;
  tdm_pkg::tdm_dither_type ditherOut;
  logic [11:0]             regAddr;
  logic                    regWrite;
  logic                    regRead;
  logic [7:0]              regWdata;
  logic [7:0]              regRdata;
  logic                    regRdataValid;
  logic                    serialLinkEnable;
  logic                    timestampPin;
  logic                    syncReceiverEnable;
  logic [7:0]              sampleIn;
  logic                    sampleInValid;
  logic [7:0]              sampleOut;
  logic                    sampleOutValid;
  logic [1:0]              ilaControlBits;
  int                      numErrors = 0;
  int                      nCompared = 0;
  int                      cycles = 0;

  tdm_regs DUT (.sys_clk(sys_clk), .rst(rst), .factoryTrim(factoryTrim), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regRdataValid(regRdataValid),
    .trimOut(trimOut), .ditherOut(ditherOut), .serialLinkEnable(serialLinkEnable), .timestampPin(timestampPin),
    .syncReceiverEnable(syncReceiverEnable), .sampleIn(sampleIn), .sampleInValid(sampleInValid),
    .sampleOut(sampleOut), .sampleOutValid(sampleOutValid), .ilaControlBits(ilaControlBits));

  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard, far above the roughly 145 cycles the tests need
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      numErrors++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      numErrors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe, dropped at the next falling edge
  task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge sys_clk);
    regWrite = 1'b0;
  endtask

  // Read answer is a one-cycle pulse, so it is judged in that cycle
  task automatic reg_read(input logic [11:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge sys_clk);
    regRead = 1'b0;
    check(32'(regRdataValid), 32'h1);
    check(32'(regRdata), 32'(exp));
  endtask

  task automatic test_reset();
    check(32'(trimOut), 32'(factoryTrim));
    reg_read(tdm_pkg::GAIN_B_ADDR, 8'h3c);
    reg_read(tdm_pkg::BANDGAP_ADDR, 8'h09);
    reg_read(tdm_pkg::TERM_A_ADDR, 8'h81);
    reg_read(tdm_pkg::TERM_B_ADDR, 8'h7e);
    reg_read(tdm_pkg::DITHER_ADDR, 8'h01);
    reg_read(tdm_pkg::MARKER_ADDR, 8'h00);
    reg_read(tdm_pkg::LINK_EN_ADDR, 8'h01);
    check(32'({ditherOut, serialLinkEnable}), 32'h9);
  endtask

  task automatic test_rw();
    reg_write(tdm_pkg::GAIN_B_ADDR, 8'h5a);
    reg_write(tdm_pkg::BANDGAP_ADDR, 8'ha6);
    reg_write(tdm_pkg::TERM_A_ADDR, 8'hc3);
    reg_write(tdm_pkg::TERM_B_ADDR, 8'h18);
    reg_write(tdm_pkg::LINK_EN_ADDR, 8'hfe);
    reg_write(tdm_pkg::MARKER_ADDR, 8'hfe);
    reg_write(12'h07d, 8'hff);
    reg_read(tdm_pkg::GAIN_B_ADDR, 8'h5a);
    reg_read(tdm_pkg::BANDGAP_ADDR, 8'ha6);
    reg_read(tdm_pkg::TERM_A_ADDR, 8'hc3);
    reg_read(tdm_pkg::TERM_B_ADDR, 8'h18);
    reg_read(tdm_pkg::LINK_EN_ADDR, 8'hfe);
    reg_read(tdm_pkg::MARKER_ADDR, 8'hfe);
    reg_read(12'h07d, 8'h00);
    check(32'(trimOut), 32'h5a6c318);
    check(32'(serialLinkEnable), 32'h0);
  endtask

  // Every combination of the three dither bits
  task automatic test_dither();
    logic [7:0] v;
    for (int i = 0; i < 8; i++)
    begin
      v = 8'(i);
      reg_write(tdm_pkg::DITHER_ADDR, v);
      reg_read(tdm_pkg::DITHER_ADDR, v);
      check(32'(ditherOut), 32'({v[0], v[1], v[2]}));
    end
  endtask

  // With marker and receiver on, a one-edge pin pulse must land on exactly one sample, seven edges later
  task automatic test_marker(input logic mk, input logic se);
    logic [7:0] exp;
    reg_write(tdm_pkg::MARKER_ADDR, {7'h00, mk});
    syncReceiverEnable = se;
    sampleIn = 8'ha5;
    sampleInValid = 1'b1;
    repeat (10) @(negedge sys_clk);
    timestampPin = 1'b1;
    for (int i = 1; i <= 9; i++)
    begin
      @(negedge sys_clk);
      timestampPin = 1'b0;
      exp = !mk ? 8'ha5 : {7'h52, (i == 7) & se};
      check(32'(sampleOut), 32'(exp));
      check(32'({sampleOutValid, ilaControlBits}), 32'h4);
    end
    sampleInValid = 1'b0;
    @(negedge sys_clk);
    check(32'(sampleOutValid), 32'h0);
  endtask

  initial
  begin
    rst = 1'b1;
    factoryTrim = 28'h3c9817e;
    regAddr = 12'h000;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWdata = 8'h00;
    timestampPin = 1'b0;
    syncReceiverEnable = 1'b0;
    sampleIn = 8'h00;
    sampleInValid = 1'b0;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    test_reset();
    test_rw();
    test_dither();
    test_marker(1'b1, 1'b1);
    test_marker(1'b1, 1'b0);
    test_marker(1'b0, 1'b1);
    end_sim();
  end
endmodule
